//--- design/adcsc_sar_core.sv
// adcsc_sar_core: successive approximation register and cycle counter
// assumes a converter clock enable pulse from the parent and a comparator input
`timescale 1ns/1ps
`default_nettype none
module adcsc_sar_core #(
  parameter int BITS = 8,
  parameter int CYCLES = 32
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic i_tick,
  input wire logic i_cmp_high,
  output logic [BITS-1:0] o_dac_code,
  output logic o_busy,
  output logic o_done,
  output logic [BITS-1:0] o_result
);
  localparam int CW = $clog2(CYCLES);
  localparam int PER_BIT = CYCLES / BITS;
  logic [CW-1:0] cnt, next_cnt;
  logic [BITS-1:0] trial, next_trial;
  logic [BITS-1:0] mask, next_mask;
  logic busy, next_busy;
  logic done, next_done;
  logic [BITS-1:0] result, next_result;

  always_comb begin
    next_cnt = cnt;
    next_trial = trial;
    next_mask = mask;
    next_busy = busy;
    next_done = 1'b0;
    next_result = result;
    if (i_abort) begin
      next_busy = 1'b0;
    end else if (i_start) begin
      next_busy = 1'b1;
      next_cnt = '0;
      next_mask = {1'b1, {(BITS-1){1'b0}}};
      next_trial = {1'b1, {(BITS-1){1'b0}}};
    end else if (busy && i_tick) begin
      next_cnt = CW'(cnt + 1'b1);
      if (cnt % CW'(PER_BIT) == CW'(PER_BIT - 1)) begin
        if (i_cmp_high) begin
          next_trial = trial & ~mask;
        end
        next_mask = mask >> 1;
        next_trial = (i_cmp_high ? (trial & ~mask) : trial) | (mask >> 1);
      end
      if (cnt == CW'(CYCLES - 1)) begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_result = i_cmp_high ? (trial & ~mask) : trial;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cnt <= '0;
      trial <= '0;
      mask <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      result <= '0;
    end else begin
      cnt <= next_cnt;
      trial <= next_trial;
      mask <= next_mask;
      busy <= next_busy;
      done <= next_done;
      result <= next_result;
    end
  end

  assign o_dac_code = trial;
  assign o_busy = busy;
  assign o_done = done;
  assign o_result = result;
endmodule
`default_nettype wire

//--- design/adcsc_top.sv
// adcsc_top: sar converter control with axi4-lite register access
// assumes an external comparator against o_dac_code and synchronous inputs
`timescale 1ns/1ps
`default_nettype none
module adcsc_top #(
  parameter int BITS = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic i_rc_osc_tick,
  input wire logic i_wait_mode,
  input wire logic i_stop_mode,
  input wire logic i_halt_mode,
  input wire logic i_cmp_high,
  input wire logic [7:0] i_port_c_pins,
  output logic [7:0] o_port_c_read,
  output logic [BITS-1:0] o_dac_code,
  output logic [1:0] o_mux_select,
  output logic [3:0] o_mux_onehot,
  output logic o_analog_power
);
  logic [7:0] ctrl, next_ctrl;
  logic done_flag, next_done_flag;
  logic [BITS-1:0] result, next_result;
  logic [1:0] aw_held, next_aw_held;
  logic [9:0] awaddr_q, next_awaddr_q;
  logic w_held, next_w_held;
  logic [31:0] wdata_q, next_wdata_q;
  logic [3:0] wstrb_q, next_wstrb_q;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic [$clog2(adcsc_pkg::SYS_PER_RC+1)-1:0] unused_div;
  logic wr_fire, rd_fire, wr_hit, rd_hit, access, tick, stopped, core_done;
  logic [BITS-1:0] core_result;
  logic [7:0] status_view;
  logic [1:0] chan;
  logic [7:0] pin_of_chan [4];

  assign stopped = i_stop_mode | i_halt_mode;
  assign chan = ctrl[adcsc_pkg::CHAN_MSB:adcsc_pkg::CHAN_LSB];
  assign unused_div = '0;

  // write address and data taken in either order
  assign s_axi_awready = !aw_held[0] && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign wr_fire = (aw_held[0] || s_axi_awvalid) && (w_held || s_axi_wvalid) && !bvalid;
  assign s_axi_arready = !rvalid;
  assign rd_fire = s_axi_arvalid && !rvalid;

  logic [9:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  assign wa = aw_held[0] ? awaddr_q : s_axi_awaddr;
  assign wd = w_held ? wdata_q : s_axi_wdata;
  assign ws = w_held ? wstrb_q : s_axi_wstrb;
  assign wr_hit = wr_fire && (wa[9:2] == adcsc_pkg::STATUS_CONTROL_INDEX ||
                              wa[9:2] == adcsc_pkg::RESULT_INDEX);
  assign rd_hit = rd_fire && (s_axi_araddr[9:2] == adcsc_pkg::STATUS_CONTROL_INDEX ||
                              s_axi_araddr[9:2] == adcsc_pkg::RESULT_INDEX);
  assign access = wr_hit || rd_hit;

  assign tick = ctrl[adcsc_pkg::RC_SEL_BIT] ? i_rc_osc_tick : 1'b1;

  assign status_view = {done_flag, ctrl[adcsc_pkg::RC_SEL_BIT], ctrl[adcsc_pkg::POWER_BIT],
                        3'b000, chan};

  always_comb begin
    next_aw_held = aw_held;
    next_awaddr_q = awaddr_q;
    next_w_held = w_held;
    next_wdata_q = wdata_q;
    next_wstrb_q = wstrb_q;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_ctrl = ctrl;
    if (wr_fire) begin
      next_aw_held = 2'b00;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = adcsc_pkg::AXI_SLVERR;
      if (wa[9:2] == adcsc_pkg::STATUS_CONTROL_INDEX) begin
        next_bresp = adcsc_pkg::AXI_OKAY;
        if (ws[0]) begin
          next_ctrl = wd[7:0] & adcsc_pkg::WRITE_MASK;
        end
      end else if (wa[9:2] == adcsc_pkg::RESULT_INDEX) begin
        next_bresp = adcsc_pkg::AXI_OKAY;
      end
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        next_aw_held = 2'b01;
        next_awaddr_q = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        next_w_held = 1'b1;
        next_wdata_q = s_axi_wdata;
        next_wstrb_q = s_axi_wstrb;
      end
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rresp = adcsc_pkg::AXI_OKAY;
      if (s_axi_araddr[9:2] == adcsc_pkg::STATUS_CONTROL_INDEX) begin
        next_rdata = {24'h000000, status_view};
      end else if (s_axi_araddr[9:2] == adcsc_pkg::RESULT_INDEX) begin
        next_rdata = {{(32-BITS){1'b0}}, result};
      end else begin
        next_rdata = 32'h00000000;
        next_rresp = adcsc_pkg::AXI_SLVERR;
      end
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_comb begin
    next_done_flag = done_flag;
    next_result = result;
    if (access || stopped) begin
      next_done_flag = 1'b0;
    end
    if (core_done && !access && !stopped) begin
      next_done_flag = 1'b1;
      next_result = core_result;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ctrl <= adcsc_pkg::STATUS_CONTROL_RESET;
      done_flag <= 1'b0;
      result <= '0;
      aw_held <= 2'b00;
      awaddr_q <= '0;
      w_held <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid <= 1'b0;
      bresp <= adcsc_pkg::AXI_OKAY;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= adcsc_pkg::AXI_OKAY;
    end else begin
      ctrl <= next_ctrl;
      done_flag <= next_done_flag;
      result <= next_result;
      aw_held <= next_aw_held;
      awaddr_q <= next_awaddr_q;
      w_held <= next_w_held;
      wdata_q <= next_wdata_q;
      wstrb_q <= next_wstrb_q;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // wait mode does not stop it
  adcsc_sar_core #(
    .BITS(BITS),
    .CYCLES(adcsc_pkg::CONV_CYCLES)
  ) u_core (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_start(access && !stopped),
    .i_abort(stopped || !ctrl[adcsc_pkg::POWER_BIT]),
    .i_tick(tick && ctrl[adcsc_pkg::POWER_BIT]),
    .i_cmp_high(i_cmp_high),
    .o_dac_code(o_dac_code),
    .o_busy(),
    .o_done(core_done),
    .o_result(core_result)
  );

  assign pin_of_chan[0] = 8'h01 << adcsc_pkg::AIN0_PIN;
  assign pin_of_chan[1] = 8'h01 << adcsc_pkg::AIN1_PIN;
  assign pin_of_chan[2] = 8'h01 << adcsc_pkg::AIN2_PIN;
  assign pin_of_chan[3] = 8'h01 << adcsc_pkg::AIN3_PIN;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_mux
      assign o_mux_onehot[g] = ctrl[adcsc_pkg::POWER_BIT] && (chan == 2'(g));
    end
  endgenerate
  assign o_mux_select = chan;
  assign o_analog_power = ctrl[adcsc_pkg::POWER_BIT] && !stopped;

  assign o_port_c_read = i_port_c_pins & ~(ctrl[adcsc_pkg::POWER_BIT] ? pin_of_chan[chan] : 8'h00);

  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
endmodule
`default_nettype wire

//--- pkg/adcsc_pkg.sv
// adcsc_pkg: register map, field positions, timing for the sar converter control
// assumes a 10 MHz system clock and axi4-lite byte addressing
package adcsc_pkg;
  // register byte addresses (result index 0x1d, status/control index chosen)
  localparam logic [7:0] RESULT_INDEX = 8'h1d;
  localparam logic [7:0] STATUS_CONTROL_INDEX = 8'h1c;
  localparam logic [9:0] RESULT_ADDR = {RESULT_INDEX, 2'b00};
  localparam logic [9:0] STATUS_CONTROL_ADDR = {STATUS_CONTROL_INDEX, 2'b00};
  // status/control field positions
  localparam int DONE_BIT = 7;
  localparam int RC_SEL_BIT = 6;
  localparam int POWER_BIT = 5;
  localparam int CHAN_LSB = 0;
  localparam int CHAN_MSB = 1;
  localparam logic [7:0] STATUS_CONTROL_RESET = 8'h00;
  localparam logic [7:0] WRITE_MASK = 8'h63;
  // conversion timing
  localparam int CONV_CYCLES = 32;
  localparam int SAR_BITS = 8;
  localparam int SYS_CLK_HZ = 10000000;
  localparam int RC_CLK_HZ = 1500000;
  localparam int SYS_PER_RC = SYS_CLK_HZ / RC_CLK_HZ;
  // port c bits carrying analog inputs 0..3
  localparam int AIN0_PIN = 6;
  localparam int AIN1_PIN = 5;
  localparam int AIN2_PIN = 4;
  localparam int AIN3_PIN = 3;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage

//--- tb/adcsc_ain_model.sv
// adcsc_ain_model: four analog sources and the comparator behind the mux
// assumes comparator high means trial code above the selected level
`timescale 1ns/1ps
`default_nettype none
module adcsc_ain_model #(
  parameter logic [31:0] LVL = 32'h0
) (
  input wire logic [7:0] i_dac_code,
  input wire logic [1:0] i_mux_select,
  output logic o_cmp_high,
  output logic [7:0] o_pins
);
  // analog pins idle high so a forced zero is visible
  assign o_pins = 8'hfd;
  assign o_cmp_high = i_dac_code > LVL[i_mux_select*8 +: 8];
endmodule
`default_nettype wire

//--- tb/adcsc_monitor.sv
// adcsc_monitor: bus and pin checks on the converter top ports
// assumes a bind into adcsc_top, one clock, sync active-low reset
`timescale 1ns/1ps
`default_nettype none
module adcsc_monitor (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic i_stop_mode,
  input wire logic [7:0] i_port_c_pins,
  input wire logic [7:0] o_port_c_read,
  input wire logic [1:0] o_mux_select,
  input wire logic [3:0] o_mux_onehot,
  input wire logic o_analog_power
);
  localparam logic [9:0] SC = adcsc_pkg::STATUS_CONTROL_ADDR;
  localparam logic [9:0] RS = adcsc_pkg::RESULT_ADDR;
  logic [7:0] gap;
  logic [7:0] next_gap;
  logic rd_take;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  assign rd_take = s_axi_arvalid && s_axi_arready;
  // edges since the last read; writes ignored so it can overestimate, unmapped reads reset it so it can underestimate
  always_comb begin
    next_gap = gap;
    if (rd_take) next_gap = 8'h00;
    else if (gap != 8'hff) next_gap = gap + 8'h01;
  end
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) gap <= 8'h00;
    else gap <= next_gap;
  end
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
  a_read_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  a_unused_zero: assert property (rd_take && s_axi_araddr == SC |=> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[4:2] == 3'h0)
    else $error("unused status bits not zero");
  a_unmapped_err: assert property (rd_take && s_axi_araddr != SC && s_axi_araddr != RS |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_early_done: assert property (rd_take && gap < 8'd30 && s_axi_araddr == SC |=> !s_axi_rdata[7])
    else $error("done flag too early");
  a_onehot_select: assert property (o_analog_power |-> o_mux_onehot == (4'h1 << o_mux_select))
    else $error("mux not routed to selected input");
  a_pin_forced: assert property (o_analog_power |-> o_port_c_read == (i_port_c_pins & ~{1'b0, o_mux_onehot[0],
    o_mux_onehot[1], o_mux_onehot[2], o_mux_onehot[3], 3'h0}))
    else $error("port read wrong for analog pin");
  a_stop_power: assert property (i_stop_mode [*2] |-> !o_analog_power)
    else $error("converter powered in stop");
  c_done_seen: cover property (s_axi_rvalid && s_axi_rdata[7]);
  c_unmapped: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
  c_stop_left: cover property (i_stop_mode ##1 !i_stop_mode);
endmodule
bind adcsc_top adcsc_monitor mon (.i_clk_sys, .i_rst_n, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .i_stop_mode,
  .i_port_c_pins, .o_port_c_read, .o_mux_select, .o_mux_onehot, .o_analog_power);
`default_nettype wire

//--- tb/test_adc_sar_control.sv
// test_adc_sar_control: register-level tests of the converter control
// assumes adcsc_top, the analog model and the bound monitor
`timescale 1ns/1ps
`default_nettype none
module test_adc_sar_control;
  localparam logic [31:0] LVL = 32'ha5ff5a00;
  localparam logic [9:0] SC = adcsc_pkg::STATUS_CONTROL_ADDR;
  localparam logic [9:0] RS = adcsc_pkg::RESULT_ADDR;
  localparam logic [1:0] OK = adcsc_pkg::AXI_OKAY;
  localparam logic [1:0] ER = adcsc_pkg::AXI_SLVERR;
  logic i_clk_sys, i_rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, i_rc_osc_tick;
  logic i_wait_mode, i_stop_mode, i_halt_mode, i_cmp_high, o_analog_power;
  logic [9:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, o_mux_onehot;
  logic [1:0] s_axi_bresp, s_axi_rresp, o_mux_select;
  logic [7:0] i_port_c_pins, o_port_c_read, o_dac_code;
  int bad_count, check_count, ch;
  adcsc_top uut (.i_clk_sys, .i_rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .i_rc_osc_tick,
    .i_wait_mode, .i_stop_mode, .i_halt_mode, .i_cmp_high, .i_port_c_pins, .o_port_c_read, .o_dac_code,
    .o_mux_select, .o_mux_onehot, .o_analog_power);
  adcsc_ain_model #(.LVL(LVL)) ain (.i_dac_code(o_dac_code), .i_mux_select(o_mux_select),
    .o_cmp_high(i_cmp_high), .o_pins(i_port_c_pins));
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // aw and w offered together, each dropped once taken
  // handshakes judged on settled values before the edge; bready and rready stay high
  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] r);
    int n;
    logic ta, tw, tb;
    logic [1:0] resp;
    resp = 2'bxx;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge i_clk_sys);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge i_clk_sys);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) break;
    end
    chk("bresp", {30'h0, r}, {30'h0, resp});
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] d, input logic [1:0] r);
    int n;
    logic ta, tr;
    logic [31:0] data;
    logic [1:0] resp;
    data = 'x;
    resp = 2'bxx;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge i_clk_sys);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      data = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge i_clk_sys);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) break;
    end
    chk("rdata", {24'h0, d}, data);
    chk("rresp", {30'h0, r}, {30'h0, resp});
  endtask
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  // rc enable every 6 system cycles, near the nominal rate
  initial begin
    i_rc_osc_tick = 1'b0;
    forever begin
      cyc(5);
      i_rc_osc_tick <= 1'b1;
      cyc(1);
      i_rc_osc_tick <= 1'b0;
    end
  end
  initial begin
    cyc(5000);
    bad_count++;
    finish_test();
  end
  initial begin
    {i_rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {i_wait_mode, i_stop_mode, i_halt_mode, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    bad_count = 0;
    check_count = 0;
    cyc(20);
    i_rst_n <= 1'b1;
    s_axi_bready <= 1'b1;
    s_axi_rready <= 1'b1;
    cyc(1);
    rd(SC, 8'h00, OK);
    rd(RS, 8'h00, OK);
    rd(10'h000, 8'h00, ER);
    wr(10'h3fc, 8'h55, ER);
    wr(SC, 8'hff, OK);
    rd(SC, 8'h63, OK);
    i_wait_mode <= 1'b1;
    for (ch = 0; ch < 4; ch++) begin
      wr(SC, {6'h08, ch[1:0]}, OK);
      cyc(2);
      chk("onehot", 32'h1 << ch, {28'h0, o_mux_onehot});
      chk("pins", {24'h0, 8'hfd & ~(8'h40 >> ch)}, {24'h0, o_port_c_read});
      cyc(40);
      rd(RS, LVL[ch*8 +: 8], OK);
      cyc(40);
      rd(SC, {6'h28, ch[1:0]}, OK);
      rd(SC, {6'h08, ch[1:0]}, OK);
    end
    i_wait_mode <= 1'b0;
    // power off: result write ignored, nothing converts
    wr(SC, 8'h03, OK);
    wr(RS, 8'h12, OK);
    cyc(40);
    rd(RS, 8'ha5, OK);
    rd(SC, 8'h03, OK);
    // slow rc clock: not done early, poll the flag
    wr(SC, 8'h61, OK);
    cyc(100);
    rd(SC, 8'h61, OK);
    cyc(250);
    rd(SC, 8'he1, OK);
    rd(RS, LVL[15:8], OK);
    // stop then halt abort a running conversion
    for (ch = 0; ch < 2; ch++) begin
      wr(SC, 8'h22, OK);
      cyc(5);
      {i_halt_mode, i_stop_mode} <= 2'b01 << ch;
      cyc(3);
      chk("power", 32'h0, {31'h0, o_analog_power});
      {i_halt_mode, i_stop_mode} <= 2'b00;
      cyc(40);
      rd(SC, 8'h22, OK);
    end
    finish_test();
  end
endmodule
`default_nettype wire
